// ===== rtl/fpeg_regs.svh
// Register offsets, field positions, reset values, key codes and timing counts
`ifndef FPEG_REGS_SVH
`define FPEG_REGS_SVH

// Avalon byte offsets, one 32-bit word each
`define FPEG_OFS_STORE_CTRL 4'h0
`define FPEG_OFS_KEY 4'h4
`define FPEG_OFS_PREFETCH 4'h8
`define FPEG_OFS_STATUS 4'hc

// Field positions
`define FPEG_SC_WRITE_EN_BIT 0
`define FPEG_SC_ERASE_EN_BIT 1
`define FPEG_PF_TWO_BYTE_BIT 0
`define FPEG_ST_BUSY_BIT 0
`define FPEG_ST_SUPPLY_BIT 1
`define FPEG_ST_ERASING_BIT 2

// Reset values
`define FPEG_STORE_CTRL_RESET 2'h0
`define FPEG_PREFETCH_RESET 1'h0

// Key codes and lock state read codes
`define FPEG_KEY_CODE_FIRST 8'ha5
`define FPEG_KEY_CODE_SECOND 8'hf1
`define FPEG_LOCK_CODE_LOCKED 2'h0
`define FPEG_LOCK_CODE_FIRST 2'h1
`define FPEG_LOCK_CODE_UNLOCKED 2'h2
`define FPEG_LOCK_CODE_DISABLED 2'h3

// Array geometry
`define FPEG_ERASED_BYTE 8'hff
`define FPEG_PAGE_BYTES 512
`define FPEG_RESERVED_TOP 6'h3f
`define FPEG_FLASH_BYTES 65536

// Timing: times as printed, cycles derived from the clock rate
`define FPEG_CLK_HZ 10000000
`define FPEG_ERASE_MIN_MS 10
`define FPEG_ERASE_MAX_MS 20
`define FPEG_WRITE_MIN_US 40
`define FPEG_WRITE_MAX_US 70
`define FPEG_ERASE_CYCLES ((`FPEG_ERASE_MIN_MS * `FPEG_CLK_HZ + 999) / 1000)
`define FPEG_WRITE_CYCLES ((`FPEG_WRITE_MIN_US * `FPEG_CLK_HZ + 999999) / 1000000)

`endif

// ===== rtl/fpeg_pkg.sv
// Types shared by the flash program and erase guard
package fpeg_pkg;

  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_FIRST,
    KEY_UNLOCKED,
    KEY_DISABLED
  } fpeg_key_state_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PROGRAM,
    SEQ_ERASE
  } fpeg_seq_state_type;

endpackage

// ===== rtl/fpeg_guard.sv
// Flash program and erase guard with key lock, timed sequencer and flash array
//
// How it works
// R1: Programming ANDs new data into a byte; only erase sets bits back to one.
// R2: Flash is 512-byte pages; erase clears one whole page.
// R3: Erase writes 0xFF to every byte of the addressed page.
// R4: Writes and erases are timed internally by a cycle counter.
// R5: CPU stall output stays high for the whole write or erase.
// R6: Flash attempt with supply monitor off raises flash-error reset, no operation.
// R7: Key register needs 0xA5 then 0xF1; spacing between writes is free.
// R8: Wrong key value or order locks flash operations until system reset.
// R9: Flash attempt before full key sequence also locks until system reset.
// R10: Each completed write or erase returns the key state to locked.
// R11: With write enable set, external-data writes go to flash, not RAM.
// R12: Write enable holds across operations; only software changes it.
// R13: Erase and write enable plus key: data write erases the containing page.
// R14: Two-byte select: zero programs single bytes, one programs aligned byte pairs.
// R15: Single-byte mode starts one programming per external-data write to flash.
// R16: Block mode buffers even byte; odd-address write starts the pair program.
// R17: A pair program takes the same cycles as a single byte.
// R18: Software writes even byte first and 0xFF for bytes to keep.
// R19: Software repeats both key codes before each byte write of a block.
// R20: Single-byte mode: software repeats key then one write per byte.
// R21: Page erase: keys, erase enable, write enable, one write, clear enables.
// R22: Page erase lasts between 10 ms and 20 ms.
// R23: Byte or pair write lasts between 40 us and 70 us.
// R24: Addresses 0xFC00 to 0xFFFF are reserved, never user flash.
// R25: Key register reads lock state: 00, 01, 10, 11.
// R26: Data byte of an erasing write is ignored.
// R27: System reset returns key state to locked and clears lockout.
`timescale 1ns/10ps

`include "fpeg_regs.svh"

module fpeg_guard #(
  parameter int unsigned ERASE_CYCLES = `FPEG_ERASE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic supply_monitor_en_i,
  input wire logic xdata_wr_i,
  input wire logic [15:0] xdata_addr_i,
  input wire logic [7:0] xdata_data_i,
  output logic xram_wr_o,
  output logic [15:0] xram_addr_o,
  output logic [7:0] xram_data_o,
  input wire logic [15:0] code_addr_i,
  output logic [7:0] code_data_o,
  output logic cpu_stall_o,
  output logic flash_error_reset_o
);

  localparam int unsigned WRITE_CYCLES = `FPEG_WRITE_CYCLES;
  localparam int unsigned PAGE_BYTES = `FPEG_PAGE_BYTES;
  // Reset image of the store control bits
  localparam logic [1:0] STORE_CTRL_RESET = `FPEG_STORE_CTRL_RESET;

  // Flash array, top kilobyte never written
  // No reset: contents survive a system reset
  logic [7:0] flash_mem [0:`FPEG_FLASH_BYTES-1];

  // Software visible state
  logic store_write_enable_reg;
  logic store_write_enable_next;
  logic store_erase_enable_reg;
  logic store_erase_enable_next;
  logic two_byte_write_select_reg;
  logic two_byte_write_select_next;
  fpeg_pkg::fpeg_key_state_type key_state_reg;
  fpeg_pkg::fpeg_key_state_type key_state_next;

  // Sequencer state
  fpeg_pkg::fpeg_seq_state_type seq_state_reg;
  fpeg_pkg::fpeg_seq_state_type seq_state_next;
  logic [31:0] cycle_cnt_reg;
  logic [31:0] cycle_cnt_next;
  logic [15:0] op_addr_reg;
  logic [15:0] op_data_reg;
  logic op_pair_reg;

  // Even byte held in block mode
  logic even_valid_reg;
  logic [15:0] even_addr_reg;
  logic [7:0] even_data_reg;

  // Bus read path
  logic rd_valid_reg;
  logic [31:0] readdata_reg;

  // Registered outputs
  logic xram_wr_reg;
  logic [15:0] xram_addr_reg;
  logic [7:0] xram_data_reg;
  logic [7:0] code_data_reg;
  logic error_reset_reg;

  // Bus decode
  wire busy = (seq_state_reg != fpeg_pkg::SEQ_IDLE);
  // Register writes wait out a running operation
  wire bus_write = avs_write_i & ~busy & avs_byteenable_i[0];
  // One wait state per read, data from a flop
  wire bus_read_load = avs_read_i & ~busy & ~rd_valid_reg;
  wire sel_store_ctrl = (avs_address_i == `FPEG_OFS_STORE_CTRL);
  wire sel_key = (avs_address_i == `FPEG_OFS_KEY);
  wire sel_prefetch = (avs_address_i == `FPEG_OFS_PREFETCH);
  wire sel_status = (avs_address_i == `FPEG_OFS_STATUS);
  wire key_write = bus_write & sel_key;
  wire [7:0] wr_byte = avs_writedata_i[7:0];

  // External-data write routing
  // Stall also drops new data writes
  wire xdata_accept = xdata_wr_i & ~busy;
  wire flash_attempt = xdata_accept & store_write_enable_reg; // R11
  wire ram_write = xdata_accept & ~store_write_enable_reg; // R11
  // Top kilobyte reserved; flash writes there are errors
  wire reserved_hit = (xdata_addr_i[15:10] == `FPEG_RESERVED_TOP); // R24
  wire error_attempt = flash_attempt & (~supply_monitor_en_i | reserved_hit); // R6 R24
  // Error attempts leave the key state alone
  wire key_open = (key_state_reg == fpeg_pkg::KEY_UNLOCKED);
  wire legal_attempt = flash_attempt & ~error_attempt;
  wire op_allowed = legal_attempt & key_open;
  wire lockout_hit = legal_attempt & ~key_open; // R9
  // Erase enable turns any unlocked, legal flash write into a page erase
  wire erase_go = op_allowed & store_erase_enable_reg; // R13
  wire write_go = op_allowed & ~store_erase_enable_reg;
  wire odd_addr = xdata_addr_i[0];
  // Even byte of a pair only fills the buffer
  wire block_even = write_go & two_byte_write_select_reg & ~odd_addr; // R14 R16
  wire block_odd = write_go & two_byte_write_select_reg & odd_addr; // R16
  wire single_go = write_go & ~two_byte_write_select_reg; // R14 R15
  wire program_go = single_go | block_odd;

  // Even byte pairs only with its own odd partner
  // Unmatched odd write programs 0xFF as its low byte and drops the even byte
  wire even_match = even_valid_reg & (even_addr_reg[15:1] == xdata_addr_i[15:1]);
  wire [7:0] pair_low = even_match ? even_data_reg : `FPEG_ERASED_BYTE; // R16
  wire [15:0] pair_addr = {xdata_addr_i[15:1], 1'b0};
  // Erase starts from the first byte of the page
  wire [15:0] page_base = {xdata_addr_i[15:9], 9'h000}; // R2

  // Timing terminals
  wire [31:0] write_last = 32'(WRITE_CYCLES - 1);
  wire [31:0] erase_last = 32'(ERASE_CYCLES - 1);
  // Stall also covers the last count
  wire write_done = (seq_state_reg == fpeg_pkg::SEQ_PROGRAM) & (cycle_cnt_reg == write_last);
  wire erase_done = (seq_state_reg == fpeg_pkg::SEQ_ERASE) & (cycle_cnt_reg == erase_last);
  wire op_done = write_done | erase_done;

  // Array write port
  // Low byte at count 0, odd byte of a pair at 1
  wire prog_low = (seq_state_reg == fpeg_pkg::SEQ_PROGRAM) & (cycle_cnt_reg == 32'h0);
  wire prog_high = (seq_state_reg == fpeg_pkg::SEQ_PROGRAM) & op_pair_reg
    & (cycle_cnt_reg == 32'h1);
  // One byte per cycle, the rest of the count is settling
  wire erase_clear = (seq_state_reg == fpeg_pkg::SEQ_ERASE)
    & (cycle_cnt_reg < 32'(PAGE_BYTES));
  wire mem_we = prog_low | prog_high | erase_clear;
  wire [15:0] mem_addr = erase_clear ? {op_addr_reg[15:9], cycle_cnt_reg[8:0]} // R2
    : (prog_high ? {op_addr_reg[15:1], 1'b1} : op_addr_reg);
  wire [7:0] mem_data = prog_high ? op_data_reg[15:8] : op_data_reg[7:0];

  // Lock state read code
  logic [1:0] lock_code;
  always_comb begin
    unique case (key_state_reg)
      fpeg_pkg::KEY_LOCKED: lock_code = `FPEG_LOCK_CODE_LOCKED; // R25
      fpeg_pkg::KEY_FIRST: lock_code = `FPEG_LOCK_CODE_FIRST; // R25
      fpeg_pkg::KEY_UNLOCKED: lock_code = `FPEG_LOCK_CODE_UNLOCKED; // R25
      fpeg_pkg::KEY_DISABLED: lock_code = `FPEG_LOCK_CODE_DISABLED; // R25
    endcase
  end

  // Read words, unused upper bits zero
  wire [31:0] store_ctrl_word = {30'h0, store_erase_enable_reg, store_write_enable_reg};
  wire [31:0] key_word = {30'h0, lock_code};
  wire [31:0] prefetch_word = {31'h0, two_byte_write_select_reg};
  wire [31:0] status_word = {29'h0, (seq_state_reg == fpeg_pkg::SEQ_ERASE),
    supply_monitor_en_i, busy};
  wire [31:0] read_mux = sel_store_ctrl ? store_ctrl_word
    : sel_key ? key_word
    : sel_prefetch ? prefetch_word
    : sel_status ? status_word
    : 32'h0;

  // Control register next values
  always_comb begin
    store_write_enable_next = store_write_enable_reg;
    store_erase_enable_next = store_erase_enable_reg;
    two_byte_write_select_next = two_byte_write_select_reg;
    // Enables change only by register writes
    if (bus_write & sel_store_ctrl) begin
      store_write_enable_next = wr_byte[`FPEG_SC_WRITE_EN_BIT]; // R12
      store_erase_enable_next = wr_byte[`FPEG_SC_ERASE_EN_BIT];
    end
    if (bus_write & sel_prefetch) begin
      two_byte_write_select_next = wr_byte[`FPEG_PF_TWO_BYTE_BIT]; // R14
    end
  end

  // Key state machine
  always_comb begin
    key_state_next = key_state_reg;
    unique case (key_state_reg)
      fpeg_pkg::KEY_LOCKED: begin
        if (lockout_hit) begin
          key_state_next = fpeg_pkg::KEY_DISABLED; // R9
        end else if (key_write) begin
          key_state_next = (wr_byte == `FPEG_KEY_CODE_FIRST)
            ? fpeg_pkg::KEY_FIRST : fpeg_pkg::KEY_DISABLED; // R7 R8
        end
      end
      fpeg_pkg::KEY_FIRST: begin
        if (lockout_hit) begin
          key_state_next = fpeg_pkg::KEY_DISABLED; // R9
        end else if (key_write) begin
          key_state_next = (wr_byte == `FPEG_KEY_CODE_SECOND)
            ? fpeg_pkg::KEY_UNLOCKED : fpeg_pkg::KEY_DISABLED; // R7 R8
        end
      end
      // A third key write counts as a wrong code
      fpeg_pkg::KEY_UNLOCKED: begin
        if (op_allowed) begin
          key_state_next = fpeg_pkg::KEY_LOCKED; // R10 R19
        end else if (key_write) begin
          key_state_next = fpeg_pkg::KEY_DISABLED; // R8
        end
      end
      // Only a system reset leaves this state
      fpeg_pkg::KEY_DISABLED: key_state_next = fpeg_pkg::KEY_DISABLED; // R8 R9
    endcase
  end

  // Operation sequencer
  always_comb begin
    seq_state_next = seq_state_reg;
    cycle_cnt_next = cycle_cnt_reg + 32'h1; // R4
    unique case (seq_state_reg)
      fpeg_pkg::SEQ_IDLE: begin
        // Counter restarts from zero for each operation
        cycle_cnt_next = 32'h0;
        if (erase_go) begin
          seq_state_next = fpeg_pkg::SEQ_ERASE; // R13
        end else if (program_go) begin
          seq_state_next = fpeg_pkg::SEQ_PROGRAM; // R15 R16
        end
      end
      fpeg_pkg::SEQ_PROGRAM: begin
        if (write_done) begin
          seq_state_next = fpeg_pkg::SEQ_IDLE; // R17 R23
        end
      end
      fpeg_pkg::SEQ_ERASE: begin
        if (erase_done) begin
          seq_state_next = fpeg_pkg::SEQ_IDLE; // R22
        end
      end
      // Unused code falls back to idle
      default: seq_state_next = fpeg_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      store_write_enable_reg <= STORE_CTRL_RESET[`FPEG_SC_WRITE_EN_BIT];
      store_erase_enable_reg <= STORE_CTRL_RESET[`FPEG_SC_ERASE_EN_BIT];
      two_byte_write_select_reg <= `FPEG_PREFETCH_RESET;
      key_state_reg <= fpeg_pkg::KEY_LOCKED; // R27
    end else begin
      store_write_enable_reg <= store_write_enable_next;
      store_erase_enable_reg <= store_erase_enable_next;
      two_byte_write_select_reg <= two_byte_write_select_next;
      key_state_reg <= key_state_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_state_reg <= fpeg_pkg::SEQ_IDLE;
      cycle_cnt_reg <= 32'h0;
    end else begin
      seq_state_reg <= seq_state_next;
      cycle_cnt_reg <= cycle_cnt_next;
    end
  end

  // Operation latch; erase drops the data byte
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_addr_reg <= 16'h0;
      op_data_reg <= 16'hffff;
      op_pair_reg <= 1'b0;
    end else if (erase_go) begin
      op_addr_reg <= page_base;
      op_data_reg <= 16'hffff; // R26
      op_pair_reg <= 1'b0;
    // Pair: odd byte high, buffered or erased byte low
    end else if (block_odd) begin
      op_addr_reg <= pair_addr;
      op_data_reg <= {xdata_data_i, pair_low}; // R16
      op_pair_reg <= 1'b1;
    end else if (single_go) begin
      op_addr_reg <= xdata_addr_i;
      op_data_reg <= {8'hff, xdata_data_i}; // R15
      op_pair_reg <= 1'b0;
    end
  end

  // Even byte buffer
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      even_valid_reg <= 1'b0;
      even_addr_reg <= 16'h0;
      even_data_reg <= 8'hff;
    end else if (block_even) begin
      even_valid_reg <= 1'b1; // R16
      even_addr_reg <= xdata_addr_i;
      even_data_reg <= xdata_data_i;
    // Any other operation drops a stale even byte
    end else if (block_odd | erase_go | single_go) begin
      even_valid_reg <= 1'b0;
    end
  end

  // Array: program only clears bits, erase sets the page to all ones
  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      flash_mem[mem_addr] <= erase_clear ? `FPEG_ERASED_BYTE // R3
        : (flash_mem[mem_addr] & mem_data); // R1
    end
    code_data_reg <= flash_mem[code_addr_i];
  end

  // Bus read data and external outputs
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_valid_reg <= 1'b0;
      readdata_reg <= 32'h0;
      xram_wr_reg <= 1'b0;
      xram_addr_reg <= 16'h0;
      xram_data_reg <= 8'h0;
      error_reset_reg <= 1'b0;
    end else begin
      rd_valid_reg <= bus_read_load;
      if (bus_read_load) begin
        readdata_reg <= read_mux;
      end
      // Plain data writes reach RAM one cycle later
      xram_wr_reg <= ram_write; // R11
      if (ram_write) begin
        xram_addr_reg <= xdata_addr_i;
        xram_data_reg <= xdata_data_i;
      end
      error_reset_reg <= error_attempt; // R6
    end
  end

  assign avs_readdata_o = readdata_reg;
  // Held off while busy and in the first read cycle
  assign avs_waitrequest_o = busy | (avs_read_i & ~rd_valid_reg);
  assign xram_wr_o = xram_wr_reg;
  assign xram_addr_o = xram_addr_reg;
  assign xram_data_o = xram_data_reg;
  assign code_data_o = code_data_reg;
  // Core stall spans the whole timed operation
  assign cpu_stall_o = busy | op_done; // R5
  assign flash_error_reset_o = error_reset_reg;

endmodule // fpeg_guard

// ===== tb/fpeg_guard_chk.sv
// Port-level checker for the flash program and erase guard
`timescale 1ns/10ps
`include "fpeg_regs.svh"
module fpeg_guard_chk #(
  parameter int unsigned ERASE_CYCLES = `FPEG_ERASE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic avs_waitrequest_o,
  input wire logic supply_monitor_en_i,
  input wire logic xdata_wr_i,
  input wire logic [15:0] xdata_addr_i,
  input wire logic [7:0] xdata_data_i,
  input wire logic xram_wr_o,
  input wire logic [15:0] xram_addr_o,
  input wire logic [7:0] xram_data_o,
  input wire logic cpu_stall_o,
  input wire logic flash_error_reset_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [31:0] stall_cnt_reg;
  logic [31:0] stall_cnt_next;
  assign stall_cnt_next = cpu_stall_o ? stall_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) stall_cnt_reg <= 32'h0;
    else stall_cnt_reg <= stall_cnt_next;
  end
  a_stall_len: assert property ($fell(cpu_stall_o) |->
    (stall_cnt_reg == `FPEG_WRITE_CYCLES || stall_cnt_reg == ERASE_CYCLES))
    else $error("stall length is neither write nor erase time");
  a_stall_wait: assert property (cpu_stall_o |-> avs_waitrequest_o)
    else $error("register bus answered during a flash operation");
  a_stall_cause: assert property ($rose(cpu_stall_o) |-> $past(xdata_wr_i) &&
    $past(supply_monitor_en_i) && $past(xdata_addr_i) < 16'hfc00)
    else $error("flash operation started without a legal write");
  a_stall_noram: assert property ($rose(cpu_stall_o) |-> !xram_wr_o)
    else $error("flash write also reached data RAM");
  a_ram_cause: assert property (xram_wr_o |-> $past(xdata_wr_i) &&
    xram_addr_o == $past(xdata_addr_i) && xram_data_o == $past(xdata_data_i))
    else $error("RAM write does not match the requested write");
  a_err_cause: assert property (flash_error_reset_o |-> $past(xdata_wr_i) &&
    (!$past(supply_monitor_en_i) || $past(xdata_addr_i) >= 16'hfc00))
    else $error("error reset without a cause");
  a_err_nostall: assert property (flash_error_reset_o |-> !cpu_stall_o)
    else $error("error reset came with a flash operation");
  a_stall_ignore: assert property (cpu_stall_o && xdata_wr_i |=>
    !xram_wr_o && !flash_error_reset_o && !$rose(cpu_stall_o))
    else $error("write during stall was not ignored");
  c_erase: cover property ($fell(cpu_stall_o) && stall_cnt_reg == ERASE_CYCLES);
  c_write: cover property ($fell(cpu_stall_o) && stall_cnt_reg == `FPEG_WRITE_CYCLES);
  c_error: cover property (flash_error_reset_o);
  c_ram: cover property (xram_wr_o);
endmodule // fpeg_guard_chk

bind fpeg_guard fpeg_guard_chk #(.ERASE_CYCLES(ERASE_CYCLES)) fpeg_guard_chk_inst (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .avs_waitrequest_o(avs_waitrequest_o),
  .supply_monitor_en_i(supply_monitor_en_i), .xdata_wr_i(xdata_wr_i),
  .xdata_addr_i(xdata_addr_i), .xdata_data_i(xdata_data_i), .xram_wr_o(xram_wr_o),
  .xram_addr_o(xram_addr_o), .xram_data_o(xram_data_o), .cpu_stall_o(cpu_stall_o),
  .flash_error_reset_o(flash_error_reset_o));

// ===== tb/fpeg_cpu_model.sv
// Processor core model issuing external-data writes
`timescale 1ns/10ps
module fpeg_cpu_model (
  input wire logic core_clk_i,
  input wire logic cpu_stall_i,
  output logic xdata_wr_o,
  output logic [15:0] xdata_addr_o,
  output logic [7:0] xdata_data_o
);
  initial begin
    xdata_wr_o = 1'b0;
    xdata_addr_o = 16'h0;
    xdata_data_o = 8'h0;
  end
  task automatic xwrite(input logic [15:0] a, input logic [7:0] d, input int gap,
    input bit wait_stall);
    repeat (gap) @(posedge core_clk_i);
    if (wait_stall) begin
      do @(negedge core_clk_i); while (cpu_stall_i !== 1'b0);
    end
    @(posedge core_clk_i);
    xdata_wr_o <= 1'b1;
    xdata_addr_o <= a;
    xdata_data_o <= d;
    @(posedge core_clk_i);
    xdata_wr_o <= 1'b0;
    // Stale operands are not left on the bus
    xdata_addr_o <= ~a;
    xdata_data_o <= ~d;
  endtask
endmodule // fpeg_cpu_model

// ===== tb/test_flash_program_erase_guard.sv
// Self-checking bench for the flash program and erase guard
`timescale 1ns/10ps
`include "fpeg_regs.svh"
module test_flash_program_erase_guard;
  localparam int unsigned ERASE_N = 600;
  logic core_clk_i, reset_n_i, avs_read_i, avs_write_i, supply_monitor_en_i, xdata_wr_i;
  logic avs_waitrequest_o, xram_wr_o, cpu_stall_o, flash_error_reset_o, seen_err, seen_ram;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [15:0] xdata_addr_i, xram_addr_o, code_addr_i, base, a, b;
  logic [7:0] xdata_data_i, xram_data_o, code_data_o, d, e;
  logic [31:0] seed = 32'h4a;
  int failures = 0;
  int tests_run = 0;
  fpeg_guard #(.ERASE_CYCLES(ERASE_N)) fpeg_guard_inst (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .supply_monitor_en_i(supply_monitor_en_i), .xdata_wr_i(xdata_wr_i),
    .xdata_addr_i(xdata_addr_i), .xdata_data_i(xdata_data_i), .xram_wr_o(xram_wr_o),
    .xram_addr_o(xram_addr_o), .xram_data_o(xram_data_o), .code_addr_i(code_addr_i),
    .code_data_o(code_data_o), .cpu_stall_o(cpu_stall_o),
    .flash_error_reset_o(flash_error_reset_o));
  fpeg_cpu_model fpeg_cpu_model_inst (.core_clk_i(core_clk_i), .cpu_stall_i(cpu_stall_o),
    .xdata_wr_o(xdata_wr_i), .xdata_addr_o(xdata_addr_i), .xdata_data_o(xdata_data_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Programming can only clear bits
  function automatic logic [7:0] exp_prog(input logic [7:0] old, input logic [7:0] nw);
    return old & nw;
  endfunction
  task automatic test_done();
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge core_clk_i);
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_address_i <= adr;
    avs_writedata_i <= wd;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] adr, input logic [31:0] exp, input string nm);
    bus(1'b0, adr, 32'h0);
    chk(nm, q, exp);
  endtask
  task automatic unlock();
    bus(1'b1, `FPEG_OFS_KEY, `FPEG_KEY_CODE_FIRST);
    repeat (rnd() % 8) @(posedge core_clk_i);
    bus(1'b1, `FPEG_OFS_KEY, `FPEG_KEY_CODE_SECOND);
  endtask
  task automatic op(input logic [15:0] adr, input logic [7:0] dat, input int n,
    input bit poke = 1'b0);
    int k;
    fpeg_cpu_model_inst.xwrite(adr, dat, rnd() % 3, 1'b1);
    @(negedge core_clk_i);
    seen_err = flash_error_reset_o;
    seen_ram = xram_wr_o;
    k = 0;
    if (poke) begin
      // Write while stalled must be dropped
      fpeg_cpu_model_inst.xwrite(adr ^ 16'h2, ~dat, 0, 1'b0);
      @(negedge core_clk_i);
      k = 2;
    end
    while (cpu_stall_o === 1'b1) begin
      k++;
      @(negedge core_clk_i);
    end
    chk("stall cycles", k, n);
  endtask
  task automatic code_chk(input logic [15:0] adr, input logic [7:0] exp);
    @(posedge core_clk_i);
    code_addr_i <= adr;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("code byte", code_data_o, exp);
  endtask
  task automatic do_reset();
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (30000) @(posedge core_clk_i);
    failures++;
    test_done();
  end
  initial begin
    {reset_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    code_addr_i = 16'h0;
    avs_byteenable_i = 4'hf;
    supply_monitor_en_i = 1'b1;
    do_reset();
    rd(`FPEG_OFS_STORE_CTRL, 32'h0, "store control");
    rd(`FPEG_OFS_PREFETCH, 32'h0, "two byte select");
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_LOCKED, "key");
    rd(4'h2, 32'h0, "unmapped");
    rd(`FPEG_OFS_STATUS, 32'h2, "status");
    avs_byteenable_i <= 4'he;
    bus(1'b1, `FPEG_OFS_STORE_CTRL, 32'h3);
    avs_byteenable_i <= 4'hf;
    rd(`FPEG_OFS_STORE_CTRL, 32'h0, "store control");
    a = 16'(rnd());
    d = 8'(rnd());
    op(a, d, 0);
    chk("ram write", seen_ram, 1'b1);
    chk("ram addr", xram_addr_o, a);
    chk("ram data", xram_data_o, d);
    base = 16'((rnd() % 126) << 9);
    bus(1'b1, `FPEG_OFS_KEY, `FPEG_KEY_CODE_FIRST);
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_FIRST, "key");
    repeat (rnd() % 40) @(posedge core_clk_i);
    bus(1'b1, `FPEG_OFS_KEY, `FPEG_KEY_CODE_SECOND);
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_UNLOCKED, "key");
    bus(1'b1, `FPEG_OFS_STORE_CTRL, 32'h3);
    op(base + 16'(rnd() % 512), 8'(rnd()), ERASE_N);
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_LOCKED, "key");
    rd(`FPEG_OFS_STORE_CTRL, 32'h3, "store control");
    code_chk(base, `FPEG_ERASED_BYTE);
    code_chk(base + 16'h1ff, `FPEG_ERASED_BYTE);
    bus(1'b1, `FPEG_OFS_STORE_CTRL, 32'h1);
    a = base + 16'(rnd() & 32'h1fe);
    d = 8'(rnd());
    e = 8'(rnd());
    unlock();
    op(a, d, `FPEG_WRITE_CYCLES);
    code_chk(a, exp_prog(`FPEG_ERASED_BYTE, d));
    unlock();
    op(a, e, `FPEG_WRITE_CYCLES, 1'b1);
    code_chk(a, exp_prog(d, e));
    bus(1'b1, `FPEG_OFS_PREFETCH, 32'h1);
    b = a ^ 16'h100;
    unlock();
    op(b, d, 0);
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_LOCKED, "key");
    unlock();
    op(b | 16'h1, e, `FPEG_WRITE_CYCLES);
    code_chk(b, exp_prog(`FPEG_ERASED_BYTE, d));
    code_chk(b | 16'h1, exp_prog(`FPEG_ERASED_BYTE, e));
    unlock();
    supply_monitor_en_i <= 1'b0;
    rd(`FPEG_OFS_STATUS, 32'h0, "status");
    op(a, d, 0);
    chk("error reset", seen_err, 1'b1);
    @(posedge core_clk_i);
    supply_monitor_en_i <= 1'b1;
    op(16'hfc00 | 16'(rnd() & 32'h3ff), d, 0);
    chk("error reset", seen_err, 1'b1);
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_UNLOCKED, "key");
    bus(1'b1, `FPEG_OFS_KEY, 32'h0);
    unlock();
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_DISABLED, "key");
    op(a, d, 0);
    chk("ram write", seen_ram, 1'b0);
    do_reset();
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_LOCKED, "key");
    bus(1'b1, `FPEG_OFS_STORE_CTRL, 32'h1);
    op(a, d, 0);
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_DISABLED, "key");
    do_reset();
    bus(1'b1, `FPEG_OFS_KEY, `FPEG_KEY_CODE_SECOND);
    rd(`FPEG_OFS_KEY, `FPEG_LOCK_CODE_DISABLED, "key");
    test_done();
  end
endmodule // test_flash_program_erase_guard
